// *** design/rcfg_regs.sv ***
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
// reference input configuration bank with profile priority store
module rcfg_regs
#(
  parameter int unsigned PROFILES = rcfg_pkg::PROF_NUM
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [rcfg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rcfg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rcfg_pkg::DATA_W-1:0] o_rdata,
  output logic o_deep_sleep,
  output rcfg_pkg::rcfg_rx_s [3:0] o_rx,
  output logic [2:0] o_threshold,
  output logic [PROFILES-1:0] o_phase_master
);

  // stored registers
  logic [7:0] pwrdn_q;
  logic [7:0] logic_q;
  logic [7:0] sel_q [2];
  logic [7:0] thresh_q;
  logic [7:0] prof_q [PROFILES];

  // bus decode
  logic wr_en;
  logic rd_en;
  logic in_prof;
  logic [2:0] prof_idx;
  logic prio_byte;

  // derived settings and outputs
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic deep_d;
  logic deep_q;
  rcfg_pkg::rcfg_rx_s [3:0] rx_d;
  rcfg_pkg::rcfg_rx_s [3:0] rx_q;
  logic [PROFILES-1:0] pm_d;
  logic [PROFILES-1:0] pm_q;

  // strobes only count while the clock enable lets state move
  assign wr_en = i_wr && i_ce;
  assign rd_en = i_rd && i_ce;
  assign in_prof = (i_addr[11:9] == rcfg_pkg::PROF_REGION);
  assign prof_idx = i_addr[rcfg_pkg::PROF_IDX_LSB +: 3];
  assign prio_byte = in_prof && (i_addr[5:0] == rcfg_pkg::PROF_PRIO_OFS);

  // power-down byte; all eight bits kept so the upper ones can be read back
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      pwrdn_q <= rcfg_pkg::RST_PWRDN;
    else if (wr_en && i_addr == rcfg_pkg::OFS_PWRDN)
      pwrdn_q <= i_wdata;
  end

  // logic family byte, input two high nibble, input one low nibble
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      logic_q <= rcfg_pkg::RST_LOGIC;
    else if (wr_en && i_addr == rcfg_pkg::OFS_LOGIC)
      logic_q <= i_wdata;
  end

  // manual profile selection, one byte per input
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      sel_q[0] <= rcfg_pkg::RST_SEL;
      sel_q[1] <= rcfg_pkg::RST_SEL;
    end
    else if (wr_en && i_addr == rcfg_pkg::OFS_SEL_ONE)
      sel_q[0] <= i_wdata;
    else if (wr_en && i_addr == rcfg_pkg::OFS_SEL_TWO)
      sel_q[1] <= i_wdata;
  end

  // threshold keeps only its three live bits; the rest read as zero
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      thresh_q <= rcfg_pkg::RST_THRESH;
    else if (wr_en && i_addr == rcfg_pkg::OFS_THRESH)
      thresh_q <= i_wdata & rcfg_pkg::THRESH_MASK;
  end

  // profile priority bytes; other profile bytes are not stored here
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      for (int p = 0; p < PROFILES; p++)
        prof_q[p] <= rcfg_pkg::RST_PROF;
    end
    else if (wr_en && prio_byte && 32'(prof_idx) < PROFILES)
      prof_q[prof_idx] <= i_wdata & rcfg_pkg::PROF_PRIO_MASK;
  end

  // read mux; unused bytes and gaps answer zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (in_prof)
    begin
      if (prio_byte && 32'(prof_idx) < PROFILES)
        rdata_d = prof_q[prof_idx];
    end
    else
    begin
      case (i_addr)
        rcfg_pkg::OFS_PWRDN: rdata_d = pwrdn_q;
        rcfg_pkg::OFS_LOGIC: rdata_d = logic_q;
        rcfg_pkg::OFS_SEL_ONE: rdata_d = sel_q[0];
        rcfg_pkg::OFS_SEL_TWO: rdata_d = sel_q[1];
        rcfg_pkg::OFS_THRESH: rdata_d = thresh_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // read data stand one enabled cycle only, then return to zero
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdata_q <= 8'h00;
    else if (i_ce)
      rdata_q <= rd_en ? rdata_d : 8'h00;
  end

  // deep sleep only when the whole byte is ones, not just the low nibble
  assign deep_d = (pwrdn_q == rcfg_pkg::DEEP_SLEEP_CODE);

  // one decoder per input: index 0/1 input one, 2/3 input two
  for (genvar g = 0; g < 2; g++)
  begin : g_input
    rcfg_rx_pair u_pair
    (
      .i_deep(deep_d),
      .i_pd(pwrdn_q[2*g +: 2]),
      .i_fam(logic_q[4*g +: 4]),
      .i_sel(sel_q[g]),
      .o_pri(rx_d[2*g]),
      .o_cmp(rx_d[2*g+1])
    );
  end

  // phase master when selection priority is numerically below threshold
  for (genvar p = 0; p < PROFILES; p++)
  begin : g_master
    assign pm_d[p] = prof_q[p][rcfg_pkg::PRIO_SEL_LSB +: 3] < thresh_q[2:0];
  end

  // registered settings toward receivers, monitors and switchover
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      deep_q <= 1'b0;
      rx_q <= '0;
      pm_q <= '0;
    end
    else if (i_ce)
    begin
      deep_q <= deep_d;
      rx_q <= rx_d;
      pm_q <= pm_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_deep_sleep = deep_q;
  assign o_rx = rx_q;
  assign o_threshold = thresh_q[2:0];
  assign o_phase_master = pm_q;

  // all-ones write to the power-down byte
  sequence s_pd_all_ones;
    wr_en && i_addr == rcfg_pkg::OFS_PWRDN && i_wdata == 8'hff;
  endsequence

  // write followed by one enabled cycle to register the result
  sequence s_pd_settle;
    s_pd_all_ones ##1 i_ce;
  endsequence

  property p_deep_sleep;
    @(posedge i_clk) disable iff (i_srst)
    s_pd_settle |=> o_deep_sleep && !o_rx[0].active && !o_rx[3].active;
  endproperty
  a_deep_sleep: assert property (p_deep_sleep)
    else $error("deep sleep not entered after all-ones power-down");

  // low nibble alone must not trigger deep sleep
  property p_no_partial_sleep;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && pwrdn_q[7:4] != 4'hf |=> !o_deep_sleep;
  endproperty
  a_no_partial_sleep: assert property (p_no_partial_sleep)
    else $error("deep sleep without upper power-down bits");

  property p_pd_bit;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && pwrdn_q[2] |=> !o_rx[2].active;
  endproperty
  a_pd_bit: assert property (p_pd_bit)
    else $error("input two primary active while powered down");

  property p_pri_runs;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && i_ce && !pwrdn_q[0] && pwrdn_q != 8'hff |=> o_rx[0].active;
  endproperty
  a_pri_runs: assert property (p_pri_runs)
    else $error("input one primary off without power-down");

  property p_diff_code;
    @(posedge i_clk) disable iff (i_srst)
    !$past(i_srst) && $past(i_ce)
      |-> o_rx[2].differential == ($past(logic_q[5:4]) == 2'h0);
  endproperty
  a_diff_code: assert property (p_diff_code)
    else $error("differential flag disagrees with family code");

  property p_cmp_ignored;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && logic_q[5:4] == 2'h0 |=> !o_rx[3].active;
  endproperty
  a_cmp_ignored: assert property (p_cmp_ignored)
    else $error("companion active beside differential primary");

  property p_fam_one;
    @(posedge i_clk) disable iff (i_srst)
    i_ce |=> o_rx[1].family == $past(logic_q[3:2]) && o_rx[0].family == $past(logic_q[1:0]);
  endproperty
  a_fam_one: assert property (p_fam_one)
    else $error("input one family fields misplaced");

  property p_manual;
    @(posedge i_clk) disable iff (i_srst)
    i_ce |=> o_rx[1].manual == $past(sel_q[0][7]) && o_rx[2].manual == $past(sel_q[1][3]);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual enable bit not followed");

  // write of a profile code seen two enabled cycles later on the receiver
  sequence s_sel_two_write;
    wr_en && i_addr == rcfg_pkg::OFS_SEL_TWO ##1 i_ce;
  endsequence

  property p_profile;
    logic [7:0] v;
    @(posedge i_clk) disable iff (i_srst)
    (s_sel_two_write, v = $past(i_wdata)) |=>
      o_rx[3].profile == v[6:4] && o_rx[2].profile == v[2:0];
  endproperty
  a_profile: assert property (p_profile)
    else $error("manual profile index not delivered");

  property p_master;
    @(posedge i_clk) disable iff (i_srst)
    i_ce |=> o_phase_master[0] == ($past(prof_q[0][2:0]) < $past(thresh_q[2:0]));
  endproperty
  a_master: assert property (p_master)
    else $error("phase master flag wrong for profile 0");

  property p_prof_reset;
    @(posedge i_clk)
    $fell(i_srst) |-> prof_q[0] == 8'h00 && prof_q[7] == 8'h00 && o_phase_master == '0;
  endproperty
  a_prof_reset: assert property (p_prof_reset)
    else $error("profile store not cleared by reset");

  property p_rsvd_read;
    @(posedge i_clk) disable iff (i_srst)
    rd_en && (i_addr == rcfg_pkg::OFS_RSVD_B || i_addr == rcfg_pkg::OFS_RSVD_A
      || i_addr == rcfg_pkg::OFS_RSVD_C) |=> o_rdata == 8'h00;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("unused byte read back non-zero");

  property p_rdata_once;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_once: assert property (p_rdata_once)
    else $error("read data held beyond its cycle");

  // input two family fields land on their own receivers
  property p_fam_two;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && i_ce |=> o_rx[3].family == $past(logic_q[7:6])
      && o_rx[2].family == $past(logic_q[5:4]);
  endproperty
  a_fam_two: assert property (p_fam_two)
    else $error("input two family fields misplaced");

  // companion runs once its pins are free and a cmos range is chosen
  property p_cmp_runs;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && i_ce && !pwrdn_q[3] && pwrdn_q != 8'hff && logic_q[5:4] != 2'h0
      && logic_q[7:6] != 2'h0 |=> o_rx[3].active;
  endproperty
  a_cmp_runs: assert property (p_cmp_runs)
    else $error("input two companion off although enabled");

  // a companion power-down bit stops its own receiver
  property p_pd_cmp;
    @(posedge i_clk) disable iff (i_srst)
    i_ce && pwrdn_q[1] |=> !o_rx[1].active;
  endproperty
  a_pd_cmp: assert property (p_pd_cmp)
    else $error("input one companion active while powered down");

  // threshold output follows the write with no extra stage
  property p_thresh_out;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && wr_en && i_addr == rcfg_pkg::OFS_THRESH
      |=> o_threshold == $past(i_wdata[2:0]);
  endproperty
  a_thresh_out: assert property (p_thresh_out)
    else $error("threshold output does not follow write");

  // priority byte keeps its used bits and drops the unused one
  property p_prio_store;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && wr_en && prio_byte && prof_idx == 3'h0
      |=> prof_q[0] == ($past(i_wdata) & rcfg_pkg::PROF_PRIO_MASK);
  endproperty
  a_prio_store: assert property (p_prio_store)
    else $error("profile priority byte stored wrongly");

  // enable and profile fields sit where the byte layout puts them
  property p_sel_layout;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && i_ce |=> o_rx[0].manual == $past(sel_q[0][3])
      && o_rx[3].manual == $past(sel_q[1][7])
      && o_rx[1].profile == $past(sel_q[0][6:4])
      && o_rx[0].profile == $past(sel_q[0][2:0]);
  endproperty
  a_sel_layout: assert property (p_sel_layout)
    else $error("selection fields misplaced");

  // a write to OFS_RSVD_A or OFS_RSVD_C leaves power-down, family, threshold and input two selection alone
  property p_rsvd_write;
    @(posedge i_clk) disable iff (i_srst)
    !i_srst && wr_en && (i_addr == rcfg_pkg::OFS_RSVD_A || i_addr == rcfg_pkg::OFS_RSVD_C)
      |=> $stable(pwrdn_q) && $stable(logic_q) && $stable(thresh_q) && $stable(sel_q[1]);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("write to unused byte changed a register");

endmodule // rcfg_regs

// *** design/rcfg_rx_pair.sv ***
`timescale 1ns/1ps
// decodes one input's primary and companion receiver settings
module rcfg_rx_pair
(
  input wire logic i_deep,
  input wire logic [1:0] i_pd,
  input wire logic [3:0] i_fam,
  input wire logic [7:0] i_sel,
  output rcfg_pkg::rcfg_rx_s o_pri,
  output rcfg_pkg::rcfg_rx_s o_cmp
);

  logic [1:0] pri_fam;
  logic [1:0] cmp_fam;
  logic pri_diff;

  assign pri_fam = i_fam[rcfg_pkg::FAM_PRI_LSB +: 2];
  assign cmp_fam = i_fam[rcfg_pkg::FAM_CMP_LSB +: 2];
  // primary family 00 pairs both pins as one differential input
  assign pri_diff = (pri_fam == rcfg_pkg::FAM_DIFF_OR_OFF);

  // primary receiver: runs unless its own bit or deep sleep stops it
  assign o_pri.active = !i_deep && !i_pd[rcfg_pkg::PD_PRI_BIT];
  assign o_pri.differential = pri_diff;
  assign o_pri.family = pri_fam;
  assign o_pri.manual = i_sel[rcfg_pkg::SEL_PRI_EN];
  assign o_pri.profile = i_sel[rcfg_pkg::SEL_PRI_LSB +: 3];

  // companion: its pin belongs to the primary while that is differential
  assign o_cmp.active = !i_deep && !i_pd[rcfg_pkg::PD_CMP_BIT] && !pri_diff
    && (cmp_fam != rcfg_pkg::FAM_DIFF_OR_OFF);
  assign o_cmp.differential = 1'b0;
  assign o_cmp.family = cmp_fam;
  assign o_cmp.manual = i_sel[rcfg_pkg::SEL_CMP_EN];
  assign o_cmp.profile = i_sel[rcfg_pkg::SEL_CMP_LSB +: 3];

endmodule // rcfg_rx_pair

// *** inc/rcfg_pkg.sv ***
// Operation
// - all eight power-down bits set puts the whole receiver section in deep sleep
// - power-down bits 3..0 each switch off one receiver; 0 runs, 1 sleeps
// - primary family 00 differential, 01/10/11 the three cmos ranges
// - companion family 00 disabled, else cmos; ignored while primary is differential
// - input one family fields sit in bits 3:2 and 1:0, same codes
// - manual-profile enable 0 gives automatic assignment, 1 the manual profile
// - three-bit manual profile field is a binary index of profiles 0 to 7
// - companion enable bit 7 with profile 6:4, primary enable 3 with 2:0
// - threshold 0..7, default 0; lower selection priority makes a phase master
// - reset clears every bit of all eight profile register sets
// - each profile holds a three-bit selection priority compared with threshold
package rcfg_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // register offsets, byte addresses
  localparam logic [11:0] OFS_PWRDN = 12'h500;
  localparam logic [11:0] OFS_LOGIC = 12'h501;
  localparam logic [11:0] OFS_RSVD_A = 12'h502;
  localparam logic [11:0] OFS_SEL_ONE = 12'h503;
  localparam logic [11:0] OFS_SEL_TWO = 12'h504;
  localparam logic [11:0] OFS_RSVD_B = 12'h505;
  localparam logic [11:0] OFS_RSVD_C = 12'h506;
  localparam logic [11:0] OFS_THRESH = 12'h507;

  // profile window: 0x600..0x7ff, eight sets of 64 bytes, priority byte first
  localparam logic [2:0] PROF_REGION = 3'h3;
  localparam int unsigned PROF_NUM = 8;
  localparam int unsigned PROF_IDX_LSB = 6;
  localparam logic [5:0] PROF_PRIO_OFS = 6'h00;
  localparam int unsigned PRIO_SEL_LSB = 0;

  // reset values
  localparam logic [7:0] RST_PWRDN = 8'h00;
  localparam logic [7:0] RST_LOGIC = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_THRESH = 8'h00;
  localparam logic [7:0] RST_PROF = 8'h00;

  // read and write masks
  localparam logic [7:0] DEEP_SLEEP_CODE = 8'hff;
  localparam logic [7:0] THRESH_MASK = 8'h07;
  localparam logic [7:0] PROF_PRIO_MASK = 8'hbf;

  // field positions inside one input's slice
  localparam int unsigned PD_PRI_BIT = 0;
  localparam int unsigned PD_CMP_BIT = 1;
  localparam int unsigned FAM_PRI_LSB = 0;
  localparam int unsigned FAM_CMP_LSB = 2;
  localparam int unsigned SEL_PRI_EN = 3;
  localparam int unsigned SEL_PRI_LSB = 0;
  localparam int unsigned SEL_CMP_EN = 7;
  localparam int unsigned SEL_CMP_LSB = 4;

  // logic family codes; 00 means differential on a primary, off on a companion
  typedef enum logic [1:0] {
    FAM_DIFF_OR_OFF = 2'h0,
    FAM_CMOS_LOW = 2'h1,
    FAM_CMOS_MID = 2'h2,
    FAM_CMOS_HIGH = 2'h3
  } rcfg_fam_e;

  // settings handed to one reference receiver
  typedef struct packed {
    logic active;
    logic differential;
    logic [1:0] family;
    logic manual;
    logic [2:0] profile;
  } rcfg_rx_s;

endpackage

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
// one comparison with four-state equality so unknowns never match
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      err_count++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end

module tb_top;
  logic i_clk, i_srst, i_ce, i_wr, i_rd;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_phase_master;
  logic o_deep_sleep;
  rcfg_pkg::rcfg_rx_s [3:0] o_rx;
  logic [2:0] o_threshold;
  int err_count;
  int tests_run;
  // shadow of what software has written, for expectations
  logic [7:0] pd_m, fam_m, sel1_m, sel2_m, th_m;
  logic [2:0] prio_m [8];
  logic [11:0] rsv [5] = '{12'h502, 12'h505, 12'h506, 12'h601, 12'h63f};

  rcfg_regs #(.PROFILES(8)) u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_deep_sleep(o_deep_sleep), .o_rx(o_rx), .o_threshold(o_threshold),
    .o_phase_master(o_phase_master));

  // 25 mhz clock
  always #20 i_clk = ~i_clk;

  task results;
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // reset held long, shadow cleared to documented defaults
  task rst;
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    {pd_m, fam_m, sel1_m, sel2_m, th_m} = '0;
    for (int n = 0; n < 8; n++) prio_m[n] = 3'h0;
    @(posedge i_clk);
  endtask

  // one-cycle write strobe; shadow ignores reserved places on purpose
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    case (a)
      12'h500: pd_m = d;
      12'h501: fam_m = d;
      12'h503: sel1_m = d;
      12'h504: sel2_m = d;
      12'h507: th_m = d & 8'h07;
      default: if (a[11:9] == 3'h3 && a[5:0] == 6'h00) prio_m[a[8:6]] = d[2:0];
    endcase
  endtask

  // read data only valid in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("rdata", e, o_rdata)
  endtask

  // expected receiver settings from the shadow registers
  function automatic rcfg_pkg::rcfg_rx_s exp_rx(input int i);
    rcfg_pkg::rcfg_rx_s r;
    logic [1:0] fp, fc;
    logic [3:0] nib;
    logic [7:0] sel;
    sel = (i < 2) ? sel1_m : sel2_m;
    nib = (i % 2 == 1) ? sel[7:4] : sel[3:0];
    fp = fam_m[(i / 2) * 4 +: 2];
    fc = fam_m[(i / 2) * 4 + 2 +: 2];
    r.family = (i % 2 == 1) ? fc : fp;
    r.manual = nib[3];
    r.profile = nib[2:0];
    r.differential = (i % 2 == 0) && (fp == 2'h0);
    r.active = !pd_m[i] && (pd_m != 8'hff) && ((i % 2 == 0) || (fc != 0 && fp != 0));
    return r;
  endfunction

  // settings outputs lag a write by one cycle, so look one edge later
  task chk;
    rcfg_pkg::rcfg_rx_s r;
    logic [7:0] pm;
    @(posedge i_clk);
    #1;
    for (int i = 0; i < 4; i++)
    begin
      r = exp_rx(i);
      `CHK("rx", {r.active, r.family, r.manual, r.profile},
        {o_rx[i].active, o_rx[i].family, o_rx[i].manual, o_rx[i].profile})
      `CHK("diff", r.differential, o_rx[i].differential)
    end
    for (int n = 0; n < 8; n++) pm[n] = prio_m[n] < th_m[2:0];
    `CHK("phase_master", pm, o_phase_master)
    `CHK("deep_sleep", pd_m == 8'hff, o_deep_sleep)
    `CHK("threshold", th_m[2:0], o_threshold)
  endtask

  // watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    results;
  end

  initial
  begin
    i_clk = 1'b0;
    i_srst = 1'b1;
    i_ce = 1'b1;
    i_addr = 12'h000;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    err_count = 0;
    tests_run = 0;
    rst;
    chk;
    for (int a = 0; a < 8; a++) rd(12'h500 + 12'(a), 8'h00);
    for (int n = 0; n < 8; n++) rd(12'h600 + 12'(n * 64), 8'h00);
    // each of power-down bits 3..0 alone, then deep sleep and its near miss
    for (int b = 0; b < 4; b++)
    begin
      wr(12'h500, 8'h01 << b);
      chk;
    end
    wr(12'h500, 8'hff);
    chk;
    rd(12'h500, 8'hff);
    wr(12'h500, 8'h7f);
    chk;
    wr(12'h500, 8'h00);
    // every primary and companion family pair, codes swapped between the input halves
    for (int p = 0; p < 4; p++)
      for (int c = 0; c < 4; c++)
      begin
        wr(12'h501, {2'(c), 2'(p), 2'(p), 2'(c)});
        chk;
      end
    // all manual enables and profile codes on all four receivers
    for (int v = 0; v < 16; v++)
    begin
      wr(12'h503, {4'(v), ~4'(v)});
      wr(12'h504, {~4'(v), 4'(v)});
      chk;
      rd(12'h504, {~4'(v), 4'(v)});
    end
    // descending priorities against every threshold
    for (int n = 0; n < 8; n++)
    begin
      wr(12'h600 + 12'(n * 64), 8'hc0 | 8'(7 - n));
      rd(12'h600 + 12'(n * 64), 8'h80 | 8'(7 - n));
    end
    for (int t = 0; t < 8; t++)
    begin
      wr(12'h507, 8'hf8 | 8'(t));
      chk;
      rd(12'h507, 8'(t));
    end
    // reserved places keep nothing; read data drops after one cycle
    for (int k = 0; k < 5; k++)
    begin
      wr(rsv[k], 8'hff);
      rd(rsv[k], 8'h00);
    end
    rd(12'h507, th_m);
    @(posedge i_clk);
    #1;
    `CHK("rdata_idle", 8'h00, o_rdata)
    // a strobe with the clock enable low must be dropped
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= 12'h500;
    i_wdata <= 8'h0f;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_ce <= 1'b1;
    rd(12'h500, pd_m);
    // second reset in mid-run clears profiles and settings again
    rst;
    chk;
    rd(12'h600 + 12'(7 * 64), 8'h00);
    rd(12'h504, 8'h00);
    results;
  end
endmodule // tb_top
